// ==== rtl/tcc_channel.sv ====
// Purpose: two capture/compare channels of a general timer
// Assumes: counter, reload and update event come from the time base outside
// Notes:   register access is by plain strobes; the compare value is per channel
// Function
// - input mode captures counter on valid edge
// - capture sets flag, gated irq and dma
// - capture with flag set sets overrun
// - flag clears by write or read; overrun by write
// - nonzero direction select means input, read-only
// - select 01 own pin, 10 neighbour pin
// - filter needs consecutive samples; 0011 means 8
// - polarity 0 rising, 1 falling
// - divider 00 captures every valid edge
// - capture needs enable; irq, dma separately gated
// - software event sets flag, irq and dma; no capture
// - trigger 101 with slave 100 resets counter
// - only channel own filtered edges trigger
// - 101 forces reference high, 100 low; polarity inverts
// - forced output still compares and flags
// - match: hold, set, clear or toggle
// - match sets flag, irq, selectable dma source
// - preload off immediate, on at update
// - update event never changes reference
// - 110 PWM1, 111 PWM2, continuous compare
// - one count resolution; reload period, compare duty
// - PWM1 high while counter below compare
`timescale 1ns/1ns
`default_nettype none
module tcc_channel (
  input  wire logic             i_clk,                    // kernel clock, 25 MHz
  input  wire logic             i_resetn,                 // sync reset, active low
  input  wire logic             i_ce,                     // clock enable
  input  wire logic [1:0]       i_timer_input_pin,        // input pins, one per channel
  input  wire logic             i_filter_sample_rate,     // filter sample strobe
  input  wire logic [15:0]      i_counter_value,          // counter value
  input  wire logic [15:0]      i_reload_value,           // auto-reload value
  input  wire logic             i_count_tick,             // counter just stepped
  input  wire logic             i_update_event,           // update event pulse
  input  wire logic [1:0][1:0]  i_channel_direction_select, // per channel
  input  wire logic [1:0][3:0]  i_input_filter_code,      // per pin
  input  wire logic [1:0]       i_channel_polarity,       // per channel
  input  wire logic [1:0][1:0]  i_capture_divider,        // per channel
  input  wire logic [1:0]       i_channel_output_enable,  // capture / output enable
  input  wire logic [1:0]       i_channel_irq_enable,     // irq enable
  input  wire logic [1:0]       i_channel_dma_enable,     // dma enable
  input  wire logic [1:0]       i_channel_sw_event,       // software event pulse
  input  wire logic [1:0][2:0]  i_output_mode_code,       // per channel
  input  wire logic [1:0]       i_compare_preload_enable, // per channel
  input  wire logic             i_dma_source_select,      // 1: dma on update event
  input  wire logic [2:0]       i_trigger_select,         // slave trigger source
  input  wire logic [2:0]       i_slave_mode_select,      // slave mode
  input  wire logic [1:0]       i_cmp_wr,                 // compare write strobe
  input  wire logic [15:0]      i_cmp_wdata,              // compare write data
  input  wire logic [1:0]       i_cmp_rd,                 // compare read strobe
  input  wire logic [1:0]       i_flag_clr,               // write zero to event flag
  input  wire logic [1:0]       i_ovr_clr,                // write zero to overrun flag
  output var  logic [1:0][15:0] o_channel_compare_value,  // visible compare value
  output var  logic [1:0]       o_channel_event_flag,     // event flag
  output var  logic [1:0]       o_channel_overrun_flag,   // overrun flag
  output var  logic [1:0]       o_irq,                    // irq pulse
  output var  logic [1:0]       o_dma_req,                // dma request pulse
  output var  logic [1:0]       o_output_reference,       // reference level
  output var  logic [1:0]       o_out_pin,                // output pin level
  output var  logic [1:0]       o_out_oe,                 // output pin enable
  output var  logic             o_counter_reset           // slave reset pulse
);
  logic [1:0]  pin_rise;
  logic [1:0]  pin_fall;
  logic [15:0] pre_q [2];
  logic [15:0] sh_q  [2];
  logic [2:0]  div_q [2];
  logic [1:0]  flag_q, ovr_q, irq_q, dma_q, ref_q, pin_q, oe_q;
  logic [1:0]  ref_d, is_in, cap, match, evt;
  logic        fp1, fp2, rst_q;

  // ----------------------------------------------------------------
  // input filters, one per pin
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_pin
    tcc_edge_if edge_if ();
    tcc_filter u_filt (
      .i_clk        (i_clk),
      .i_resetn     (i_resetn),
      .i_ce         (i_ce),
      .i_pin        (i_timer_input_pin[p]),
      .i_sample_tick(i_filter_sample_rate),
      .i_code       (i_input_filter_code[p]),
      .o_edge       (edge_if)
    );
    assign pin_rise[p] = edge_if.rise;
    assign pin_fall[p] = edge_if.fall;
  end

  // only each pin's own channel edge feeds the slave trigger
  assign fp1 = i_channel_polarity[0] ? pin_fall[0] : pin_rise[0];
  assign fp2 = i_channel_polarity[1] ? pin_fall[1] : pin_rise[1];

  // ----------------------------------------------------------------
  // per-channel logic
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic       sel_edge;
    logic       fire;
    logic [2:0] mask;
    logic       below;

    assign is_in[c] = i_channel_direction_select[c] != tcc_pkg::SEL_OUTPUT;

    // route own or neighbour pin, then pick the active edge
    always_comb begin
      sel_edge = 1'b0;
      if (i_channel_direction_select[c] == tcc_pkg::SEL_OWN_PIN) begin
        sel_edge = i_channel_polarity[c] ? pin_fall[c] : pin_rise[c];
      end else if (i_channel_direction_select[c] == tcc_pkg::SEL_NBR_PIN) begin
        sel_edge = i_channel_polarity[c] ? pin_fall[1-c] : pin_rise[1-c];
      end
    end

    // divider 00 keeps mask zero so every edge fires
    assign mask  = {i_capture_divider[c] == 2'h3, i_capture_divider[c][1],
                    i_capture_divider[c] != 2'h0};
    assign fire  = (div_q[c] & mask) == mask;
    assign cap[c]   = sel_edge & fire & i_channel_output_enable[c];
    assign match[c] = ~is_in[c] & i_count_tick & (i_counter_value == sh_q[c]);
    assign evt[c]   = cap[c] | match[c] | i_channel_sw_event[c];
    // a compare above the reload value is never reached, so the level stays high
    assign below    = (i_counter_value < sh_q[c]) | (sh_q[c] > i_reload_value);

    // edge divider; held clear while capture is off
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        div_q[c] <= 3'h0;
      end else if (i_ce) begin
        if (!i_channel_output_enable[c] || !is_in[c]) begin
          div_q[c] <= 3'h0;
        end else if (sel_edge) begin
          div_q[c] <= fire ? 3'h0 : div_q[c] + 3'h1;
        end
      end
    end

    // software-visible value: capture writes it, software only in output mode
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        pre_q[c] <= tcc_pkg::CMP_RST;
      end else if (i_ce) begin
        if (cap[c]) begin
          pre_q[c] <= i_counter_value;
        end else if (!is_in[c] && i_cmp_wr[c]) begin
          pre_q[c] <= i_cmp_wdata;
        end
      end
    end

    // shadow value: immediate without preload, at update event with it
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        sh_q[c] <= tcc_pkg::CMP_RST;
      end else if (i_ce) begin
        if (cap[c]) begin
          sh_q[c] <= i_counter_value;
        end else if (!is_in[c] && !i_compare_preload_enable[c] && i_cmp_wr[c]) begin
          sh_q[c] <= i_cmp_wdata;
        end else if (!is_in[c] && i_compare_preload_enable[c] && i_update_event) begin
          sh_q[c] <= pre_q[c];
        end
      end
    end

    // flags: a setting event wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        flag_q[c] <= 1'b0;
        ovr_q[c]  <= 1'b0;
      end else if (i_ce) begin
        if (evt[c]) begin
          flag_q[c] <= 1'b1;
        end else if (i_flag_clr[c] || (i_cmp_rd[c] && is_in[c])) begin
          flag_q[c] <= 1'b0;
        end
        if (cap[c] && flag_q[c]) begin
          ovr_q[c] <= 1'b1;
        end else if (i_ovr_clr[c]) begin
          ovr_q[c] <= 1'b0;
        end
      end
    end

    // requests are single-cycle pulses, gated by their own enables
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        irq_q[c] <= 1'b0;
        dma_q[c] <= 1'b0;
      end else if (i_ce) begin
        irq_q[c] <= evt[c] & i_channel_irq_enable[c];
        dma_q[c] <= i_channel_dma_enable[c] &
                    (i_dma_source_select ? i_update_event : evt[c]);
      end
    end

    // reference next value; the update event is not an input here
    always_comb begin
      ref_d[c] = ref_q[c];
      if (!is_in[c]) begin
        unique case (tcc_pkg::tcc_mode_e'(i_output_mode_code[c]))
          tcc_pkg::MODE_FROZEN:   ref_d[c] = ref_q[c];
          tcc_pkg::MODE_SET:      ref_d[c] = match[c] ? 1'b1 : ref_q[c];
          tcc_pkg::MODE_CLEAR:    ref_d[c] = match[c] ? 1'b0 : ref_q[c];
          tcc_pkg::MODE_TOGGLE:   ref_d[c] = match[c] ^ ref_q[c];
          tcc_pkg::MODE_FORCE_LO: ref_d[c] = 1'b0;
          tcc_pkg::MODE_FORCE_HI: ref_d[c] = 1'b1;
          tcc_pkg::MODE_PWM1:     ref_d[c] = below;
          tcc_pkg::MODE_PWM2:     ref_d[c] = ~below;
        endcase
      end
    end

    // pin follows reference, inverted by polarity; driven only as output
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        ref_q[c] <= tcc_pkg::REF_RST;
        pin_q[c] <= tcc_pkg::REF_RST;
        oe_q[c]  <= 1'b0;
      end else if (i_ce) begin
        ref_q[c] <= ref_d[c];
        pin_q[c] <= ref_d[c] ^ i_channel_polarity[c];
        oe_q[c]  <= ~is_in[c] & i_channel_output_enable[c];
      end
    end

    assign o_channel_compare_value[c] = pre_q[c];
  end

  // ----------------------------------------------------------------
  // slave reset trigger
  // ----------------------------------------------------------------
  // the counter lives outside; this only asks it to restart on the chosen edge
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rst_q <= 1'b0;
    end else if (i_ce) begin
      rst_q <= (i_slave_mode_select == tcc_pkg::SLAVE_RESET) &
               (((i_trigger_select == tcc_pkg::TRIG_FP1) & fp1) |
                ((i_trigger_select == tcc_pkg::TRIG_FP2) & fp2));
    end
  end

  assign o_channel_event_flag   = flag_q;
  assign o_channel_overrun_flag = ovr_q;
  assign o_irq                  = irq_q;
  assign o_dma_req              = dma_q;
  assign o_output_reference     = ref_q;
  assign o_out_pin              = pin_q;
  assign o_out_oe               = oe_q;
  assign o_counter_reset        = rst_q;

  // ----------------------------------------------------------------
  // checks on channel 0
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  cap_copy_a: assert property (i_ce && cap[0] |=> pre_q[0] == $past(i_counter_value))
    else $error("capture did not copy counter");
  flag_set_a: assert property (i_ce && evt[0] |=> o_channel_event_flag[0])
    else $error("event flag not set");
  ovr_set_a: assert property (i_ce && cap[0] && flag_q[0] |=> o_channel_overrun_flag[0])
    else $error("overrun flag not set");
  ovr_hold_a: assert property (i_ce && ovr_q[0] && !i_ovr_clr[0] |=> ovr_q[0])
    else $error("overrun flag cleared without write");
  read_only_a: assert property (i_ce && is_in[0] && !cap[0] |=> $stable(pre_q[0]))
    else $error("input-mode compare value changed");
  irq_gate_a: assert property (o_irq[0] |-> $past(i_channel_irq_enable[0]))
    else $error("irq without enable");
  sw_event_a: assert property (i_ce && i_channel_sw_event[0] && i_channel_irq_enable[0]
                               |=> o_irq[0] && o_channel_event_flag[0])
    else $error("software event gave no irq");
  force_pin_a: assert property (i_ce && !is_in[0] && i_output_mode_code[0] == 3'b101
                                |=> ref_q[0] && (o_out_pin[0] != $past(i_channel_polarity[0])))
    else $error("forced high not seen on pin");
  toggle_a: assert property (i_ce && !is_in[0] && i_output_mode_code[0] == 3'b011
                             && match[0] |=> ref_q[0] != $past(ref_q[0]))
    else $error("toggle on match failed");
  pwm1_a: assert property (i_ce && !is_in[0] && i_output_mode_code[0] == 3'b110
                           |=> ref_q[0] == (($past(i_counter_value) < $past(sh_q[0]))
                                            || ($past(sh_q[0]) > $past(i_reload_value))))
    else $error("pwm mode 1 level wrong");
  preload_a: assert property (i_ce && !is_in[0] && i_compare_preload_enable[0]
                              && !i_update_event |=> $stable(sh_q[0]))
    else $error("shadow changed without update");
  slave_rst_a: assert property (i_ce && i_slave_mode_select == 3'b100
                                && i_trigger_select == 3'b101 && fp1 |=> o_counter_reset)
    else $error("slave reset missing");

  capture_c: cover property (i_ce && cap[0] ##1 o_channel_event_flag[0]);
  overrun_c: cover property (o_channel_overrun_flag[0]);
  pwm_c:     cover property (!is_in[0] && i_output_mode_code[0] == 3'b110 && ref_q[0]);
  reset_c:   cover property (o_counter_reset);
endmodule : tcc_channel
`default_nettype wire

// ==== rtl/tcc_edge_if.sv ====
// Purpose: carries one filtered input level and its edge pulses
// Assumes: single clock domain
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
interface tcc_edge_if;
  logic level; // filtered level
  logic rise;  // accepted rising transition
  logic fall;  // accepted falling transition
  modport src (output level, rise, fall);
  modport snk (input level, rise, fall);
endinterface : tcc_edge_if
`default_nettype wire

// ==== rtl/tcc_filter.sv ====
// Purpose: digital input filter and edge detector for one timer input pin
// Assumes: pin is synchronous to i_clk
// Notes:   level changes only after a run of equal samples at the sample tick
`timescale 1ns/1ns
`default_nettype none
module tcc_filter (
  input  wire logic       i_clk,         // kernel clock
  input  wire logic       i_resetn,      // sync reset, active low
  input  wire logic       i_ce,          // clock enable
  input  wire logic       i_pin,         // raw input pin level
  input  wire logic       i_sample_tick, // filter sample rate strobe
  input  wire logic [3:0] i_code,        // input filter code
  tcc_edge_if.src         o_edge         // filtered level and edges
);
  logic       lvl_q;
  logic [3:0] run_q;
  logic       rise_q;
  logic       fall_q;
  logic [3:0] run_nx;
  logic [3:0] need;

  assign run_nx = run_q + 4'h1;
  assign need   = tcc_pkg::filt_len(i_code);

  // ----------------------------------------------------------------
  // run-length filter
  // ----------------------------------------------------------------
  // a glitch shorter than the run resets the count, so it never leaks out
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      lvl_q  <= tcc_pkg::REF_RST;
      run_q  <= 4'h0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (i_ce) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (i_sample_tick) begin
        if (i_pin == lvl_q) begin
          run_q <= 4'h0;
        end else if (run_nx >= need) begin
          lvl_q  <= i_pin;
          run_q  <= 4'h0;
          rise_q <= i_pin;
          fall_q <= ~i_pin;
        end else begin
          run_q <= run_nx;
        end
      end
    end
  end

  assign o_edge.level = lvl_q;
  assign o_edge.rise  = rise_q;
  assign o_edge.fall  = fall_q;
endmodule : tcc_filter
`default_nettype wire

// ==== rtl/tcc_pkg.sv ====
// Purpose: shared constants and types of the timer capture/compare channel block
// Assumes: 16-bit counter, two channels with one input pin each
// Notes:   filter lengths are sample counts at the filter sample rate
package tcc_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NCH   = 2;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_OUTPUT  = 2'h0;
  localparam logic [1:0] SEL_OWN_PIN = 2'h1;
  localparam logic [1:0] SEL_NBR_PIN = 2'h2;
  localparam logic [2:0] TRIG_FP1    = 3'h5;
  localparam logic [2:0] TRIG_FP2    = 3'h6;
  localparam logic [2:0] SLAVE_RESET = 3'h4;

  // output reference modes
  typedef enum logic [2:0] {
    MODE_FROZEN   = 3'b000,
    MODE_SET      = 3'b001,
    MODE_CLEAR    = 3'b010,
    MODE_TOGGLE   = 3'b011,
    MODE_FORCE_LO = 3'b100,
    MODE_FORCE_HI = 3'b101,
    MODE_PWM1     = 3'b110,
    MODE_PWM2     = 3'b111
  } tcc_mode_e;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
  localparam logic             REF_RST = 1'b0;

  // ----------------------------------------------------------------
  // filter lengths: consecutive samples needed per filter code
  // ----------------------------------------------------------------
  localparam logic [3:0] FILT_LEN_0 = 4'h1;
  localparam logic [3:0] FILT_LEN_1 = 4'h2;
  localparam logic [3:0] FILT_LEN_2 = 4'h4;
  localparam logic [3:0] FILT_LEN_3 = 4'h8;
  localparam logic [3:0] FILT_LEN_X = 4'h8;

  function automatic logic [3:0] filt_len(input logic [3:0] code);
    unique case (code)
      4'h0:    filt_len = FILT_LEN_0;
      4'h1:    filt_len = FILT_LEN_1;
      4'h2:    filt_len = FILT_LEN_2;
      4'h3:    filt_len = FILT_LEN_3;
      default: filt_len = FILT_LEN_X;
    endcase
  endfunction : filt_len
endpackage : tcc_pkg

// ==== tb/tcc_channel_tb.sv ====
// Purpose: self-checking bench of the capture/compare channel pair
// Assumes: bench plays the time base; counter steps every cycle
// Notes:   filter sample strobe held high, so one sample per cycle
`timescale 1ns/1ns
`default_nettype none
module tcc_channel_tb;
  logic i_clk, i_resetn, i_ce, i_filter_sample_rate, i_count_tick, i_update_event;
  logic i_dma_source_select, run, src_pin, o_counter_reset, r, e;
  logic [1:0] i_channel_polarity, i_channel_output_enable, i_timer_input_pin;
  logic [1:0] i_channel_irq_enable, i_channel_dma_enable, i_channel_sw_event, o_out_oe;
  logic [1:0] i_compare_preload_enable, i_cmp_wr, i_cmp_rd, i_flag_clr, i_ovr_clr;
  logic [1:0] o_channel_event_flag, o_channel_overrun_flag, o_irq, o_dma_req;
  logic [1:0] o_output_reference, o_out_pin;
  logic [2:0] i_trigger_select, i_slave_mode_select;
  logic [7:0] per, high;
  logic [15:0] i_counter_value, i_reload_value, i_cmp_wdata;
  logic [1:0][1:0] i_channel_direction_select, i_capture_divider;
  logic [1:0][3:0] i_input_filter_code;
  logic [1:0][2:0] i_output_mode_code;
  logic [1:0][15:0] o_channel_compare_value;
  logic [31:0] rs = 32'hdaf0_d9e3;
  int n_errors = 0, checked = 0, cnt = 0, wrap = 255, m, sh, shn, p;

  assign i_timer_input_pin = {1'b0, src_pin};
  tcc_channel dut_u (.*);
  tcc_pulse_src src_u (.i_clk(i_clk), .i_run(run), .i_per(per), .i_high(high), .o_pin(src_pin));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  // one cycle; strobes drop after their taking edge, counter obeys slave reset
  task automatic step(input int n = 1);
    repeat (n) begin
      @(posedge i_clk);
      #1;
      {i_cmp_wr, i_cmp_rd, i_flag_clr, i_ovr_clr, i_channel_sw_event} = '0;
      i_update_event = 1'b0;
      cnt = (o_counter_reset || cnt >= wrap) ? 0 : cnt + 1;
      i_counter_value = cnt[15:0];
    end
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("comparisons=%0d mismatches=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // the run needs under a thousand cycles; twenty thousand means a hang
  initial begin
    #800_000;
    n_errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_cmp_wr, i_cmp_rd, i_flag_clr, i_ovr_clr, i_channel_sw_event} = '0;
    {i_update_event, i_count_tick, i_dma_source_select, run, i_resetn} = '0;
    {i_ce, i_filter_sample_rate} = 2'h3;
    {i_reload_value, i_cmp_wdata, i_counter_value} = {16'h000f, 32'h0000_0000};
    {i_channel_direction_select, i_capture_divider, i_input_filter_code} = '0;
    {i_output_mode_code, i_channel_polarity, i_compare_preload_enable} = '0;
    {i_channel_output_enable, i_channel_irq_enable, i_channel_dma_enable} = 6'h3f;
    {i_trigger_select, i_slave_mode_select, per, high} = {6'h00, 8'd20, 8'd7};
    repeat (5) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    // pwm input: ch0 rising on its own pin, ch1 falling on the neighbour pin
    i_channel_direction_select = {2'b10, 2'b01};
    i_channel_polarity = 2'b10;
    {i_trigger_select, i_slave_mode_select} = {3'b101, 3'b100};
    run = 1'b1;
    step(70);
    chk(o_channel_compare_value[0], 16'(per - 1));
    chk(o_channel_compare_value[1], 16'(high - 1));
    chk({o_channel_overrun_flag, o_channel_event_flag}, 4'hf);
    run = 1'b0;
    step(5);
    // read clears the flag only; a write in input mode is refused
    {i_cmp_rd, i_cmp_wr, i_cmp_wdata} = {4'h5, 16'h1234};
    step(1);
    chk({o_channel_overrun_flag[0], o_channel_event_flag[0]}, 2'b10);
    chk(o_channel_compare_value[0], 16'(per - 1));
    i_ovr_clr = 2'b01;
    step(1);
    chk(o_channel_overrun_flag[0], 1'b0);
    // filter code 0011: seven high samples rejected, eight accepted
    {i_trigger_select, i_slave_mode_select, per, high} = {6'h00, 8'd40, 8'd7};
    i_input_filter_code[0] = 4'h3;
    run = 1'b1;
    step(80);
    chk(o_channel_event_flag[0], 1'b0);
    high = 8'd8;
    step(80);
    chk(o_channel_event_flag[0], 1'b1);
    run = 1'b0;
    // software event, then dma taken from the update event
    i_channel_sw_event = 2'b10;
    step(1);
    chk({o_irq[1], o_dma_req[1], o_channel_event_flag[1]}, 3'b111);
    step(1);
    chk({o_irq[1], o_dma_req[1]}, 2'b00);
    {i_dma_source_select, i_update_event} = 2'b11;
    step(1);
    chk(o_dma_req[1], 1'b1);
    // divider 01: the first accepted rise is skipped, the second one captures
    {i_capture_divider[0], i_flag_clr, run} = {2'b01, 2'b01, 1'b1};
    step(60);
    chk(o_channel_event_flag[0], 1'b0);
    step(40);
    chk(o_channel_event_flag[0], 1'b1);
    {i_capture_divider[0], run} = 3'h0;
    // output compare and forced modes, immediate compare writes
    {i_dma_source_select, i_channel_direction_select, wrap} = {5'h00, 32'd15};
    for (m = 0; m < 6; m++) begin
      rs = xs(rs);
      {i_output_mode_code[0], i_channel_polarity[0]} = {3'(m), rs[0]};
      {i_flag_clr, i_cmp_wr, i_cmp_wdata} = {4'h5, 12'h000, rs[7:4]};
      sh = int'(rs[7:4]);
      step(1);
      {r, i_count_tick} = {o_output_reference[0], 1'b1};
      step(16);
      e = (m == 1 || m == 5) ? 1'b1 : (m == 3) ? ~r : (m == 0) ? r : 1'b0;
      chk({o_out_oe[0], o_out_pin[0], o_output_reference[0]}, {1'b1, e ^ rs[0], e});
      chk({o_channel_event_flag[0], 1'b0}, {1'b1, 1'b0});
      {i_update_event, i_count_tick} = 2'b10;
      step(2);
      chk(o_output_reference[0], e);
    end
    // pwm 1 and 2 with preload: old duty until the update event
    i_compare_preload_enable = 2'b01;
    for (int k = 0; k < 6; k++) begin
      rs = xs(rs);
      shn = (k < 2) ? int'(rs[3:0]) : (k < 4) ? 0 : 20;
      {m, i_output_mode_code[0], i_channel_polarity[0]} = {((k % 2) ? 32'd7 : 32'd6), 3'(m), 1'b0};
      i_output_mode_code[0] = 3'(m);
      {i_cmp_wr, i_cmp_wdata} = {2'b01, 16'(shn)};
      for (int j = 0; j < 44; j++) begin
        if (j == 20) i_update_event = 1'b1;
        if (j == 21) sh = shn;
        p = cnt;
        step(1);
        if (j % 22 > 1) chk(o_output_reference[0], (p < sh) ^ (m == 7));
      end
    end
    close_out();
  end
endmodule : tcc_channel_tb
`default_nettype wire

// ==== tb/tcc_pulse_src.sv ====
// Purpose: pulse source model standing on a timer input pin
// Assumes: one clock; the pin moves just after the rising edge
// Notes:   idle low while stopped, as on a pulled-down line
`timescale 1ns/1ns
`default_nettype none
module tcc_pulse_src (
  input  wire logic       i_clk,  // bench clock
  input  wire logic       i_run,  // source running
  input  wire logic [7:0] i_per,  // period in cycles
  input  wire logic [7:0] i_high, // high time in cycles
  output var  logic       o_pin   // pin level
);
  int ph = 0;
  initial o_pin = 1'b0;
  // phase counter; a stopped source restarts its period, so no stale level lingers
  always @(posedge i_clk) begin
    #1;
    ph = (i_run && ph + 1 < int'(i_per)) ? ph + 1 : 0;
    o_pin = i_run && (ph < int'(i_high));
  end
endmodule : tcc_pulse_src
`default_nettype wire
